// ===== logic/ramp_profile_defines.vh
// Constants for the accel/decel profile selector
`ifndef RAMP_PROFILE_DEFINES_VH
`define RAMP_PROFILE_DEFINES_VH
`define APB_OFF_PATTERN      12'h000
`define APB_OFF_ACC1         12'h004
`define APB_OFF_DEC1         12'h008
`define APB_OFF_ACC2         12'h00C
`define APB_OFF_DEC2         12'h010
`define APB_OFF_MAP          12'h014
`define APB_OFF_TERM_FUNC    12'h018
`define APB_OFF_STATUS       12'h01C
`define APB_OFF_CURVE_LEN    12'h020
`define PAT_LINEAR           2'h0
`define PAT_S_FIXED          2'h1
`define PAT_S_PARAM          2'h2
`define PATTERN_RST          2'h0
`define RATIO_MAX            7'h32
`define RATIO_RST            7'h00
`define MAP_RST              14'h270F
`define MAP_MAX              14'h03E7
`define MAP_ALL_OFF          14'h270F
`define FIXED_S_RATIO        7'h32
`define TERM_FUNC_RST        8'h00
`define CURVE_LEN_RST        16'h0100
`endif

// ===== logic/ramp_curve_gen.v
// Speed ramp step generator: linear or S-curve toward a target
`timescale 1ns/1ps
module ramp_curve_gen #(
   parameter W = 16
) (
   // Clock and reset
   input  wire         i_sys_clk,
   input  wire         i_resetn,
   // Command
   input  wire [W-1:0] i_target,
   input  wire [6:0]   i_ratio,
   input  wire [15:0]  i_ramp_len,
   // State
   output reg  [W-1:0] o_speed,
   output reg          o_busy,
   output reg          o_accel
);
   reg  [15:0] step_cnt_ff;
   reg  [15:0] nxt_step_cnt;
   reg  [W-1:0] nxt_speed;
   wire [22:0] curve_prod;
   wire [22:0] curve_quot;
   wire [15:0] curve_len;
   wire        in_curve;
   wire        do_step;

   // Curved part length = ramp_len * ratio / 100, full-width product
   assign curve_prod = i_ramp_len * i_ratio;
   assign curve_quot = curve_prod / 23'd100;
   assign curve_len  = curve_quot[15:0];
   assign in_curve  = (step_cnt_ff < curve_len);
   // Inside the eased portion step only every other cycle
   assign do_step   = !in_curve || step_cnt_ff[0];

   always @* begin
      nxt_speed    = o_speed;
      nxt_step_cnt = step_cnt_ff;
      if (o_speed == i_target) begin
         nxt_step_cnt = 16'h0000;
      end else begin
         if (step_cnt_ff != 16'hFFFF)
            nxt_step_cnt = step_cnt_ff + 16'h0001;
         if (do_step) begin
            if (i_target > o_speed)
               nxt_speed = o_speed + {{(W-1){1'b0}}, 1'b1};
            else
               nxt_speed = o_speed - {{(W-1){1'b0}}, 1'b1};
         end
      end
   end

   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_speed     <= {W{1'b0}};
         o_busy      <= 1'b0;
         o_accel     <= 1'b0;
         step_cnt_ff <= 16'h0000;
      end else begin
         o_speed     <= nxt_speed;
         step_cnt_ff <= nxt_step_cnt;
         o_busy      <= (nxt_speed != i_target);
         o_accel     <= (i_target > nxt_speed);
      end
   end
endmodule

// ===== logic/accel_decel_profile_selector.v
// Accel/decel profile selector with APB parameter store
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
`include "ramp_profile_defines.vh"
// Functional notes
// - Pattern 0 gives straight-line ramps
// - Pattern 1 gives fixed S-curve ramps
// - Pattern 2 uses ratio settings, switchable
// - Ratios are percent of ramp, 0-50
// - Pattern accepts only 0, 1, 2
// - Map digits select terminals one to three
// - Switch off uses first ratios, on second
// - Switch changes ignored during a ramp
module accel_decel_profile_selector #(
   parameter W = 16
) (
   // Clock and reset
   input  wire         i_sys_clk,
   input  wire         i_resetn,
   // APB slave
   input  wire         i_psel,
   input  wire         i_penable,
   input  wire         i_pwrite,
   input  wire [11:0]  i_paddr,
   input  wire [31:0]  i_pwdata,
   output reg  [31:0]  o_prdata,
   output reg          o_pready,
   output reg          o_pslverr,
   // Terminals and speed command
   input  wire [2:0]   i_input_terminal,
   input  wire [W-1:0] i_target_speed,
   // Drive state
   output reg  [W-1:0] o_present_speed,
   output reg          o_ramp_busy,
   output reg          o_second_set,
   output reg  [2:0]   o_terminal_general
);
   reg  [1:0]  ramp_pattern_select_ff;
   reg  [6:0]  s_accel_ratio_first_ff;
   reg  [6:0]  s_decel_ratio_first_ff;
   reg  [6:0]  s_accel_ratio_second_ff;
   reg  [6:0]  s_decel_ratio_second_ff;
   reg  [13:0] switch_input_map_ff;
   reg  [7:0]  input_terminal_function_map_ff;
   reg  [15:0] curve_len_ff;
   reg  [2:0]  term_meta_ff;
   reg  [2:0]  term_sync_ff;
   reg         set_sel_ff;
   reg         busy_d_ff;
   reg  [6:0]  nxt_ratio;
   reg  [31:0] nxt_rdata;
   reg         nxt_err;
   wire [3:0]  digit [0:2];
   wire [13:0] map_hund;
   wire [13:0] map_tens;
   wire [13:0] map_ones;
   wire        accel_now;
   wire [2:0]  is_switch;
   wire        switch_in;
   wire        wr_en;
   wire        acc_ph;
   wire [W-1:0] gen_speed;
   wire        gen_busy;
   wire        gen_accel;
   wire [W-1:0] target_hold;

   // Map digits: hundreds=terminal one, tens=two, ones=three
   assign map_hund = switch_input_map_ff / 14'd100;
   assign map_tens = (switch_input_map_ff / 14'd10) % 14'd10;
   assign map_ones = switch_input_map_ff % 14'd10;
   assign digit[0] = (switch_input_map_ff == `MAP_ALL_OFF) ? 4'hF :
                     map_hund[3:0];
   assign digit[1] = (switch_input_map_ff == `MAP_ALL_OFF) ? 4'hF :
                     map_tens[3:0];
   assign digit[2] = (switch_input_map_ff == `MAP_ALL_OFF) ? 4'hF :
                     map_ones[3:0];

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_term
         assign is_switch[g] = (digit[g] == 4'h1);
      end
   endgenerate

   assign switch_in = |(is_switch & term_sync_ff);
   assign acc_ph    = i_psel && i_penable;
   assign wr_en     = acc_ph && i_pwrite && !o_pready;
   assign target_hold = i_target_speed;
   // Direction from live target so the first ramp step uses the right ratio
   assign accel_now   = (i_target_speed > gen_speed);

   // Ratio selection by pattern, phase and latched set
   always @* begin
      case (ramp_pattern_select_ff)
         `PAT_LINEAR:  nxt_ratio = 7'h00;
         `PAT_S_FIXED: nxt_ratio = `FIXED_S_RATIO;
         `PAT_S_PARAM: begin
            if (accel_now)
               nxt_ratio = set_sel_ff ? s_accel_ratio_second_ff
                                      : s_accel_ratio_first_ff;
            else
               nxt_ratio = set_sel_ff ? s_decel_ratio_second_ff
                                      : s_decel_ratio_first_ff;
         end
         default:      nxt_ratio = 7'h00;
      endcase
   end

   ramp_curve_gen #(
      .W (W)
   ) u_gen (
      .i_sys_clk  (i_sys_clk),
      .i_resetn   (i_resetn),
      .i_target   (target_hold),
      .i_ratio    (nxt_ratio),
      .i_ramp_len (curve_len_ff),
      .o_speed    (gen_speed),
      .o_busy     (gen_busy),
      .o_accel    (gen_accel)
   );

   // Read mux
   always @* begin
      nxt_rdata = 32'h0000_0000;
      nxt_err   = 1'b0;
      case (i_paddr)
         `APB_OFF_PATTERN:   nxt_rdata[1:0]  = ramp_pattern_select_ff;
         `APB_OFF_ACC1:      nxt_rdata[6:0]  = s_accel_ratio_first_ff;
         `APB_OFF_DEC1:      nxt_rdata[6:0]  = s_decel_ratio_first_ff;
         `APB_OFF_ACC2:      nxt_rdata[6:0]  = s_accel_ratio_second_ff;
         `APB_OFF_DEC2:      nxt_rdata[6:0]  = s_decel_ratio_second_ff;
         `APB_OFF_MAP:       nxt_rdata[13:0] = switch_input_map_ff;
         `APB_OFF_TERM_FUNC: nxt_rdata[7:0]  = input_terminal_function_map_ff;
         `APB_OFF_STATUS:    nxt_rdata[4:0]  = {set_sel_ff, gen_accel,
                                                gen_busy, switch_in,
                                                busy_d_ff};
         `APB_OFF_CURVE_LEN: nxt_rdata[15:0] = curve_len_ff;
         default:            nxt_err         = 1'b1;
      endcase
   end

   // APB: one wait state, answer in second access cycle
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h0000_0000;
      end else begin
         o_pready  <= acc_ph && !o_pready;
         o_pslverr <= acc_ph && !o_pready && nxt_err;
         if (acc_ph && !o_pready && !i_pwrite)
            o_prdata <= nxt_rdata;
      end
   end

   // Settings store with range checks
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ramp_pattern_select_ff         <= `PATTERN_RST;
         s_accel_ratio_first_ff         <= `RATIO_RST;
         s_decel_ratio_first_ff         <= `RATIO_RST;
         s_accel_ratio_second_ff        <= `RATIO_RST;
         s_decel_ratio_second_ff        <= `RATIO_RST;
         switch_input_map_ff            <= `MAP_RST;
         input_terminal_function_map_ff <= `TERM_FUNC_RST;
         curve_len_ff                   <= `CURVE_LEN_RST;
      end else if (wr_en) begin
         case (i_paddr)
            `APB_OFF_PATTERN:
               if (i_pwdata <= 32'h0000_0002)
                  ramp_pattern_select_ff <= i_pwdata[1:0];
            `APB_OFF_ACC1:
               if (i_pwdata <= {25'h0, `RATIO_MAX})
                  s_accel_ratio_first_ff <= i_pwdata[6:0];
            `APB_OFF_DEC1:
               if (i_pwdata <= {25'h0, `RATIO_MAX})
                  s_decel_ratio_first_ff <= i_pwdata[6:0];
            `APB_OFF_ACC2:
               if (i_pwdata <= {25'h0, `RATIO_MAX})
                  s_accel_ratio_second_ff <= i_pwdata[6:0];
            `APB_OFF_DEC2:
               if (i_pwdata <= {25'h0, `RATIO_MAX})
                  s_decel_ratio_second_ff <= i_pwdata[6:0];
            `APB_OFF_MAP:
               if (i_pwdata <= {18'h0, `MAP_MAX} ||
                   i_pwdata == {18'h0, `MAP_ALL_OFF})
                  switch_input_map_ff <= i_pwdata[13:0];
            `APB_OFF_TERM_FUNC:
               input_terminal_function_map_ff <= i_pwdata[7:0];
            `APB_OFF_CURVE_LEN:
               curve_len_ff <= i_pwdata[15:0];
            default: ;
         endcase
      end
   end

   // Terminal synchroniser, ratio-set latch, outputs
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         term_meta_ff       <= 3'h0;
         term_sync_ff       <= 3'h0;
         set_sel_ff         <= 1'b0;
         busy_d_ff          <= 1'b0;
         o_present_speed    <= {W{1'b0}};
         o_ramp_busy        <= 1'b0;
         o_second_set       <= 1'b0;
         o_terminal_general <= 3'h0;
      end else begin
         term_meta_ff <= i_input_terminal;
         term_sync_ff <= term_meta_ff;
         busy_d_ff    <= gen_busy;
         // Latch only while no ramp runs; held for the ramp
         if (!gen_busy)
            set_sel_ff <= switch_in;
         o_present_speed    <= gen_speed;
         o_ramp_busy        <= gen_busy;
         o_second_set       <= set_sel_ff;
         o_terminal_general <= term_sync_ff & ~is_switch;
      end
   end
endmodule

// ===== tb/ramp_profile_props.sv
// Port checker for the accel/decel profile selector
`timescale 1ns/1ps
`include "ramp_profile_defines.vh"
module ramp_profile_props #(parameter W = 16) (
   // Clock, reset and APB
   input wire i_sys_clk, input wire i_resetn, input wire i_psel,
   input wire i_penable, input wire i_pwrite, input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata, input wire [31:0] o_prdata,
   input wire o_pready, input wire o_pslverr,
   // Terminals and drive state
   input wire [2:0] i_input_terminal, input wire [W-1:0] i_target_speed,
   input wire [W-1:0] o_present_speed, input wire o_ramp_busy,
   input wire o_second_set, input wire [2:0] o_terminal_general
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   sequence s_access; i_psel && i_penable && !o_pready; endsequence
   sequence s_read(a); o_pready && !i_pwrite && i_paddr == a; endsequence
   property p_ready; s_access |=> o_pready; endproperty
   a_ready: assert property (p_ready) else $error("no ready");
   property p_pulse; o_pready |=> !o_pready; endproperty
   a_pulse: assert property (p_pulse) else $error("long ready");
   property p_err; o_pready && i_paddr[1:0] == 2'h0 |->
      o_pslverr == (i_paddr > `APB_OFF_CURVE_LEN); endproperty
   a_err: assert property (p_err) else $error("bad slverr");
   property p_pat; s_read(`APB_OFF_PATTERN) |->
      o_prdata <= 32'h0000_0002; endproperty
   a_pat: assert property (p_pat) else $error("pattern range");
   property p_map; s_read(`APB_OFF_MAP) |->
      o_prdata <= 32'h0000_03E7 || o_prdata == 32'h0000_270F; endproperty
   a_map: assert property (p_map) else $error("map range");
   property p_step; o_present_speed == $past(o_present_speed) ||
      o_present_speed == $past(o_present_speed) + 1'b1 ||
      o_present_speed == $past(o_present_speed) - 1'b1; endproperty
   a_step: assert property (p_step) else $error("speed jump");
   property p_busy; o_present_speed != i_target_speed |-> ##[0:2]
      (o_ramp_busy || o_present_speed == i_target_speed); endproperty
   a_busy: assert property (p_busy) else $error("idle off target");
   property p_frozen; o_ramp_busy && $past(o_ramp_busy) |->
      $stable(o_second_set); endproperty
   a_frozen: assert property (p_frozen) else $error("set moved");
endmodule
bind accel_decel_profile_selector ramp_profile_props #(.W(W)) u_props (
   .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
   .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
   .o_pslverr(o_pslverr), .i_input_terminal(i_input_terminal),
   .i_target_speed(i_target_speed), .o_present_speed(o_present_speed),
   .o_ramp_busy(o_ramp_busy), .o_second_set(o_second_set),
   .o_terminal_general(o_terminal_general));

// ===== tb/terminal_source.sv
// Far-side model: terminal levels and speed command source
`timescale 1ns/1ps
module terminal_source (
   // Clock, reset and drive state
   input  wire i_sys_clk, input wire i_resetn, input wire i_busy,
   // Requests from the bench
   input  wire [15:0] i_target_req, input wire [2:0] i_term_req,
   input  wire i_force,
   // Lines toward the drive
   output reg  [15:0] o_target_speed, output reg [2:0] o_input_terminal
);
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_target_speed <= 16'h0000;
         o_input_terminal <= 3'h0;
      end else if (!i_busy || i_force) begin
         o_input_terminal <= i_term_req;
         if (!i_busy) o_target_speed <= i_target_req;
      end
   end
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the accel/decel profile selector
`timescale 1ns/1ps
module testbench;
   reg i_sys_clk = 0, i_resetn = 0, psel = 0, penable = 0, pwrite = 0;
   reg [11:0] paddr = 0;
   reg [31:0] pwdata = 0, seed = 32'h0000_002F, rd_v;
   reg [15:0] req_target = 0;
   reg [2:0] req_term = 0;
   reg req_force = 0, rd_e;
   wire [31:0] prdata;
   wire pready, pslverr, busy, second_set;
   wire [15:0] target, speed;
   wire [2:0] term, term_general;
   integer failures = 0, checked = 0, cycles = 0, base_up, base_dn;
   integer n, i, s, mdl [0:8];
   accel_decel_profile_selector #(.W(16)) DUT (.i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_input_terminal(term), .i_target_speed(target),
      .o_present_speed(speed), .o_ramp_busy(busy),
      .o_second_set(second_set), .o_terminal_general(term_general));
   terminal_source u_src (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
      .i_busy(busy), .i_target_req(req_target), .i_term_req(req_term),
      .i_force(req_force), .o_target_speed(target),
      .o_input_terminal(term));
   initial begin
      forever #2.5 i_sys_clk = ~i_sys_clk;
   end
   always @(posedge i_sys_clk) begin
      cycles = cycles + 1;
      if (cycles == 30000) begin
         failures = failures + 1;
         end_sim;
      end
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic int legal(int x, int d);
      return x == 0 ? d <= 2 : x < 5 ? d <= 50 : x > 5 || d < 1000 || d == 9999;
   endfunction
   function automatic int claim(int m);
      return m == 9999 ? 0 : (m / 100 == 1) | ((m / 10 % 10 == 1) << 1)
         | ((m % 10 == 1) << 2);
   endfunction
   function automatic int extra(int acc, int sec);
      int r;
      r = mdl[0] == 0 ? 0 : mdl[0] == 1 ? 50 : mdl[acc ? 1 + 2*sec : 2 + 2*sec];
      return (mdl[8] * r / 100 + 1) / 2;
   endfunction
   task check(input [31:0] got, input [31:0] exp);
      checked = checked + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task apb(input w, input int idx, input int d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= 12'(idx * 4);
      pwdata <= d;
      @(posedge i_sys_clk);
      penable <= 1'b1;
      @(posedge i_sys_clk);
      while (pready !== 1'b1) @(posedge i_sys_clk);
      rd_v = prdata;
      rd_e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge i_sys_clk);
      if (w && legal(idx, d)) mdl[idx] = idx == 6 ? d % 256 : d;
      if (!w && idx < 9) check(rd_v, mdl[idx]);
      check(rd_e, idx > 8);
   endtask
   task ramp(input int tgt);
      n = 0;
      req_target <= tgt[15:0];
      @(posedge i_sys_clk);
      while (speed !== tgt[15:0]) begin
         @(posedge i_sys_clk);
         n = n + 1;
      end
      repeat (4) @(posedge i_sys_clk);
   endtask
   task pair(input int sec);
      ramp(60);
      check(n - base_up, extra(1, sec));
      ramp(0);
      check(n - base_dn, extra(0, sec));
   endtask
   task set_term(input int m, input [2:0] t);
      apb(1, 5, m);
      req_term <= t;
      repeat (8) @(posedge i_sys_clk);
      s = (t & claim(mdl[5])) != 0;
      check(term_general, t & ~claim(mdl[5]));
      check(second_set, s);
   endtask
   task end_sim;
      if (failures == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      mdl = '{0, 0, 0, 0, 0, 9999, 0, 0, 256};
      repeat (3) @(posedge i_sys_clk);
      i_resetn <= 1'b1;
      @(posedge i_sys_clk);
      for (i = 0; i < 9; i++) if (i != 7) apb(0, i, 0);
      apb(1, 0, 3);
      apb(1, 1, 51);
      apb(1, 5, 1000);
      for (i = 1; i < 7; i++) apb(1, i, rnd() % (i > 4 ? 1000 : 51));
      for (i = 0; i < 9; i++) if (i != 7) apb(0, i, 0);
      apb(0, 9, 0);
      check(rd_e, 1);
      foreach (mdl[i]) if (i > 0 && i < 9 && i != 7)
         apb(1, i, i == 1 ? 25 : i == 2 ? 10 : i == 3 ? 50 : i == 8 ? 40 : 0);
      apb(1, 5, 9999);
      ramp(60);
      base_up = n;
      ramp(0);
      base_dn = n;
      check(base_up >= 60 && base_up < 64 && base_dn == base_up, 1);
      for (i = 1; i < 3; i++) begin
         apb(1, i, 20 * i);
         apb(1, 0, i);
         pair(0);
      end
      for (i = 0; i < 7; i++) begin
         set_term(i < 4 ? (i == 0 ? 10 : i == 1 ? 20 : i == 2 ? 111 : 9999)
            : rnd() % 1000, i < 4 ? 3'b111 : rnd());
         pair(s);
      end
      set_term(111, 3'b000);
      fork
         ramp(60);
         begin
            repeat (10) @(posedge i_sys_clk);
            req_force <= 1'b1;
            req_term <= 3'b111;
         end
      join
      check(n - base_up, extra(1, 0));
      req_force <= 1'b0;
      ramp(0);
      check(n - base_dn, extra(0, 1));
      end_sim;
   end
endmodule
